// ### macrs_register_set.v
// macrs_register_set.v: software-visible register set of the multiply-accumulate coprocessor
// assumes the cpu core presents sfr accesses and coprocessor updates synchronous to ref_clk
//
// Behaviour
// - two 16-bit pointers plus pointer and gpr offset registers, all read/write
// - offset bit 0 is always zero, writes ignored there
// - accumulator is 40 bits: low word, high word, status low byte
// - high word bits 31:16, low word 15:0, status 7:0 bits 39:32
// - accumulator words refuse bit-level instruction writes
// - status bit 15 interrupt request, set on request, cleared by a status write of zero; bit 14 reserved
// - sticky limit set on saturation or min/max change; software clears
// - extension flag set when extension byte is significant after operation
// - sticky overflow set on 40-bit overflow; software clears
// - carry flag set on carry or borrow
// - bit 9 zero result, bit 8 negative result
// - flags change only on evaluating coprocessor instructions, not on moves
// - control bit 15 is the global interrupt enable
// - control bits 14..11 mask limit, extension, overflow, carry flags
// - control bit 10 selects product one-bit left shift for signed products
// - control bit 9 selects 32-bit saturation; bits 8:0 reserved
// - repeat bit 15 set while repeated instruction executes
// - repeat bits 12:0 hold executions minus one
// - single-byte regular write clears the other byte
// - unimplemented bits ignore writes, read zero
// - reachable as sfrs; status, accumulator, control and repeat also by side-effect-free coprocessor store
// - coprocessor store decodes the 5-bit register address map
// - limited high read gives 7fff/8000 when extension significant
// - each repeat iteration tests count: zero ends, else decrement
`timescale 1ns/1ps
`include "macrs_regs.vh"

module macrs_register_set (
  // clock and reset
  input wire ref_clk,
  input wire rst_n,
  // sfr access from the core
  input wire sfr_wr,
  input wire sfr_bit_op,
  input wire [4:0] sfr_sel,
  input wire [1:0] sfr_byte_en,
  input wire [15:0] sfr_wdata,
  output reg [15:0] sfr_rdata,
  // coprocessor store read port
  input wire [4:0] coproc_store_instruction_addr,
  output reg [15:0] coproc_store_instruction_rdata,
  // datapath updates from coprocessor instructions
  input wire acc_load,
  input wire [39:0] acc_next_in,
  input wire flags_eval,
  input wire res_carry,
  input wire res_overflow,
  input wire res_saturated,
  input wire minmax_changed,
  // repeat unit
  input wire repeat_load,
  input wire [12:0] repeat_load_count,
  input wire repeat_step,
  output wire repeat_done,
  // control outputs to the datapath and interrupt system
  output wire [39:0] accumulator,
  output wire product_shift_mode,
  output wire saturation_mode,
  output wire [15:0] operand_pointer_zero,
  output wire [15:0] operand_pointer_one,
  output wire [15:0] pointer_offset_0,
  output wire [15:0] pointer_offset_1,
  output wire [15:0] gpr_pointer_offset_0,
  output wire [15:0] gpr_pointer_offset_1,
  output wire irq_out
);

  reg [15:0] ptr_reg [0:1];
  reg [15:0] ofs_reg [0:3];
  reg [15:0] acc_high_reg;
  reg [15:0] acc_low_reg;
  reg [15:0] status_reg;
  reg [15:0] control_reg;
  reg [15:0] repeat_reg;
  reg [15:0] status_next;
  reg [15:0] repeat_next;
  reg [39:0] acc_val;
  reg irq_cond;
  wire ext_sig;

  // merge a byte-lane write; the unaddressed byte is cleared
  function [15:0] lane_merge;
    input [1:0] be;
    input [15:0] wd;
    begin
      case (be)
        2'b01: lane_merge = {8'h00, wd[7:0]};
        2'b10: lane_merge = {wd[15:8], 8'h00};
        default: lane_merge = wd;
      endcase
    end
  endfunction

  // limiter on the high word
  function [15:0] limit_high;
    input ext;
    input neg;
    input [15:0] hi;
    begin
      if (!ext)
        limit_high = hi;
      else if (neg)
        limit_high = `MACRS_LIM_NEG;
      else
        limit_high = `MACRS_LIM_POS;
    end
  endfunction

  wire [15:0] wr_word = lane_merge(sfr_byte_en, sfr_wdata);
  wire wr_hit = sfr_wr && (sfr_byte_en != 2'b00);

  assign accumulator = {status_reg[7:0], acc_high_reg, acc_low_reg};
  assign product_shift_mode = control_reg[`MACRS_CW_MP];
  assign saturation_mode = control_reg[`MACRS_CW_MS];
  assign operand_pointer_zero = ptr_reg[0];
  assign operand_pointer_one = ptr_reg[1];
  assign pointer_offset_0 = ofs_reg[0];
  assign pointer_offset_1 = ofs_reg[1];
  assign gpr_pointer_offset_0 = ofs_reg[2];
  assign gpr_pointer_offset_1 = ofs_reg[3];
  assign repeat_done = repeat_step && (repeat_reg[12:0] == 13'h0000);
  assign ext_sig = status_reg[`MACRS_ST_EXT];

  // pointers and offsets
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_ptr
      // select worked out at full width, then cut to the 5-bit select on purpose
      localparam [31:0] SEL_W = `MACRS_SFR_PTR0 + gi;
      always @(posedge ref_clk) begin
        if (!rst_n)
          ptr_reg[gi] <= `MACRS_RESET_WORD;
        else if (wr_hit && sfr_sel == SEL_W[4:0])
          ptr_reg[gi] <= wr_word;
      end
    end
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_ofs
      localparam [31:0] SEL_W = `MACRS_SFR_QX0 + gi;
      always @(posedge ref_clk) begin
        if (!rst_n)
          ofs_reg[gi] <= `MACRS_RESET_WORD;
        else if (wr_hit && sfr_sel == SEL_W[4:0])
          ofs_reg[gi] <= wr_word & `MACRS_OFS_WMASK;
      end
    end
  endgenerate

  // accumulator words; datapath load has priority over software
  always @* begin
    acc_val = acc_next_in;
  end

  always @(posedge ref_clk) begin
    if (!rst_n) begin
      acc_high_reg <= `MACRS_RESET_WORD;
      acc_low_reg <= `MACRS_RESET_WORD;
    end else if (acc_load) begin
      acc_high_reg <= acc_val[31:16];
      acc_low_reg <= acc_val[15:0];
    end else if (wr_hit && !sfr_bit_op) begin
      // bit-level writes ignored: words sit in non bit-addressable space
      if (sfr_sel == `MACRS_CO_ACC_HIGH)
        acc_high_reg <= wr_word;
      if (sfr_sel == `MACRS_CO_ACC_LOW)
        acc_low_reg <= wr_word;
    end
  end

  // interrupt condition from masked flags
  always @* begin
    irq_cond = control_reg[`MACRS_CW_GIE] &&
      ((status_reg[`MACRS_ST_LIMIT] && control_reg[`MACRS_CW_LM]) ||
       (status_reg[`MACRS_ST_EXT] && control_reg[`MACRS_CW_EM]) ||
       (status_reg[`MACRS_ST_OVF] && control_reg[`MACRS_CW_VM]) ||
       (status_reg[`MACRS_ST_CARRY] && control_reg[`MACRS_CW_CM]));
  end

  assign irq_out = irq_cond;

  // status word next value; hardware sets win over software clears
  always @* begin
    status_next = status_reg;
    if (wr_hit && sfr_sel == `MACRS_CO_STATUS)
      status_next = (status_reg & ~`MACRS_ST_WMASK) | (wr_word & `MACRS_ST_WMASK);
    if (acc_load)
      status_next[7:0] = acc_val[39:32];
    if (flags_eval) begin
      status_next[`MACRS_ST_EXT] = (acc_val[39:31] != 9'h000) && (acc_val[39:31] != 9'h1ff);
      status_next[`MACRS_ST_CARRY] = res_carry;
      status_next[`MACRS_ST_ZERO] = (acc_val == 40'h0000000000);
      status_next[`MACRS_ST_NEG] = acc_val[39];
      if (res_overflow)
        status_next[`MACRS_ST_OVF] = 1'b1;
      if (res_saturated || minmax_changed)
        status_next[`MACRS_ST_LIMIT] = 1'b1;
    end
    // request flag is sticky; the handler clears it through sfr space
    if (wr_hit && sfr_sel == `MACRS_CO_STATUS && !wr_word[`MACRS_ST_IRQ] && !irq_cond)
      status_next[`MACRS_ST_IRQ] = 1'b0;
    if (irq_cond)
      status_next[`MACRS_ST_IRQ] = 1'b1;
    status_next[14] = 1'b0;
  end

  always @(posedge ref_clk) begin
    if (!rst_n)
      status_reg <= `MACRS_RESET_WORD;
    else
      status_reg <= status_next;
  end

  always @(posedge ref_clk) begin
    if (!rst_n)
      control_reg <= `MACRS_RESET_WORD;
    else if (wr_hit && sfr_sel == `MACRS_CO_CONTROL)
      control_reg <= wr_word & `MACRS_CW_WMASK;
  end

  // repeat word: count and active flag
  always @* begin
    repeat_next = repeat_reg;
    if (wr_hit && sfr_sel == `MACRS_CO_REPEAT)
      repeat_next = wr_word & `MACRS_RW_WMASK;
    if (repeat_load)
      repeat_next = {1'b1, 2'b00, repeat_load_count};
    else if (repeat_step) begin
      if (repeat_reg[12:0] == 13'h0000)
        repeat_next[`MACRS_RW_ACTIVE] = 1'b0;
      else begin
        repeat_next[12:0] = repeat_reg[12:0] - 13'h0001;
        repeat_next[`MACRS_RW_ACTIVE] = 1'b1;
      end
    end
  end

  always @(posedge ref_clk) begin
    if (!rst_n)
      repeat_reg <= `MACRS_RESET_WORD;
    else
      repeat_reg <= repeat_next;
  end

  // sfr read and coprocessor store read share one decoder
  function [15:0] read_mux;
    input [4:0] a;
    begin
      case (a)
        `MACRS_CO_STATUS: read_mux = status_reg;
        `MACRS_CO_ACC_HIGH: read_mux = acc_high_reg;
        `MACRS_CO_LIMITED: read_mux = limit_high(ext_sig, status_reg[`MACRS_ST_NEG], acc_high_reg);
        `MACRS_CO_ACC_LOW: read_mux = acc_low_reg;
        `MACRS_CO_CONTROL: read_mux = control_reg;
        `MACRS_CO_REPEAT: read_mux = repeat_reg;
        `MACRS_SFR_PTR0: read_mux = ptr_reg[0];
        `MACRS_SFR_PTR1: read_mux = ptr_reg[1];
        `MACRS_SFR_QX0: read_mux = ofs_reg[0];
        `MACRS_SFR_QX1: read_mux = ofs_reg[1];
        `MACRS_SFR_QR0: read_mux = ofs_reg[2];
        `MACRS_SFR_QR1: read_mux = ofs_reg[3];
        default: read_mux = 16'h0000;
      endcase
    end
  endfunction

  // registered reads; no state changes on read
  always @(posedge ref_clk) begin
    if (!rst_n) begin
      sfr_rdata <= 16'h0000;
      coproc_store_instruction_rdata <= 16'h0000;
    end else begin
      sfr_rdata <= read_mux(sfr_sel);
      coproc_store_instruction_rdata <= (coproc_store_instruction_addr < `MACRS_SFR_PTR0) ? read_mux(coproc_store_instruction_addr) : 16'h0000;
    end
  end

endmodule // macrs_register_set

// ### macrs_regs.vh
// macrs_regs.vh: offsets, field positions and constants of the mac register set
// assumes inclusion by the register-set module only
`ifndef MACRS_REGS_VH
`define MACRS_REGS_VH
// 5-bit coprocessor register addresses
`define MACRS_CO_STATUS 5'h00
`define MACRS_CO_ACC_HIGH 5'h01
`define MACRS_CO_LIMITED 5'h02
`define MACRS_CO_ACC_LOW 5'h04
`define MACRS_CO_CONTROL 5'h05
`define MACRS_CO_REPEAT 5'h06
// sfr-side selects (own index space for pointers and offsets)
`define MACRS_SFR_PTR0 5'h08
`define MACRS_SFR_PTR1 5'h09
`define MACRS_SFR_QX0 5'h0a
`define MACRS_SFR_QX1 5'h0b
`define MACRS_SFR_QR0 5'h0c
`define MACRS_SFR_QR1 5'h0d
// status word fields
`define MACRS_ST_IRQ 15
`define MACRS_ST_LIMIT 13
`define MACRS_ST_EXT 12
`define MACRS_ST_OVF 11
`define MACRS_ST_CARRY 10
`define MACRS_ST_ZERO 9
`define MACRS_ST_NEG 8
`define MACRS_ST_WMASK 16'h3fff
// control word fields
`define MACRS_CW_GIE 15
`define MACRS_CW_LM 14
`define MACRS_CW_EM 13
`define MACRS_CW_VM 12
`define MACRS_CW_CM 11
`define MACRS_CW_MP 10
`define MACRS_CW_MS 9
`define MACRS_CW_WMASK 16'hfe00
// repeat word fields
`define MACRS_RW_ACTIVE 15
`define MACRS_RW_WMASK 16'h9fff
`define MACRS_OFS_WMASK 16'hfffe
// limiter answers
`define MACRS_LIM_POS 16'h7fff
`define MACRS_LIM_NEG 16'h8000
// reset value (none documented)
`define MACRS_RESET_WORD 16'h0000
`endif

// ### macrs_host_model.sv
// host core model: issues sfr and coprocessor store accesses
// assumes the register set answers one edge after the select
`timescale 1ns/1ps
module macrs_host_model (
  // clock
  input wire ref_clk,
  // answers
  input wire [15:0] sfr_rdata,
  input wire [15:0] coproc_store_instruction_rdata,
  // requests
  output logic sfr_wr,
  output logic sfr_bit_op,
  output logic [4:0] sfr_sel,
  output logic [1:0] sfr_byte_en,
  output logic [15:0] sfr_wdata,
  output logic [4:0] coproc_store_instruction_addr
);
  initial begin
    {sfr_wr, sfr_bit_op, sfr_sel, sfr_byte_en, sfr_wdata, coproc_store_instruction_addr} = '0;
  end
  task wr(input [4:0] s, input [1:0] b, input [15:0] d, input bo);
    @(posedge ref_clk) #1;
    {sfr_wr, sfr_bit_op, sfr_sel, sfr_byte_en, sfr_wdata} = {1'b1, bo, s, b, d};
    @(posedge ref_clk) #1;
    {sfr_wr, sfr_bit_op, sfr_byte_en} = '0;
    // released data lines do not hold their value
    sfr_wdata = ~d;
  endtask
  task rd(input [4:0] s, output [15:0] d);
    @(posedge ref_clk) #1;
    sfr_sel = s;
    @(posedge ref_clk) #1;
    d = sfr_rdata;
  endtask
  task co(input [4:0] a, output [15:0] d);
    @(posedge ref_clk) #1;
    coproc_store_instruction_addr = a;
    @(posedge ref_clk) #1;
    d = coproc_store_instruction_rdata;
  endtask
  // handler clears the request before it returns
  task ack;
    wr(5'h00, 2'b11, 16'h0000, 1'b0);
  endtask
endmodule // macrs_host_model

// ### macrs_register_set_monitor.sv
// checker of the mac register set, bound to its ports
// assumes one clock domain and the active-low synchronous reset
`timescale 1ns/1ps
module macrs_rs_monitor (
  input wire ref_clk,
  input wire rst_n,
  input wire sfr_wr,
  input wire sfr_bit_op,
  input wire [4:0] sfr_sel,
  input wire [1:0] sfr_byte_en,
  input wire [15:0] sfr_wdata,
  input wire [15:0] sfr_rdata,
  input wire [4:0] coproc_store_instruction_addr,
  input wire [15:0] coproc_store_instruction_rdata,
  input wire acc_load,
  input wire [39:0] acc_next_in,
  input wire repeat_load,
  input wire [12:0] repeat_load_count,
  input wire repeat_step,
  input wire repeat_done,
  input wire [39:0] accumulator,
  input wire product_shift_mode,
  input wire saturation_mode,
  input wire [15:0] pointer_offset_0,
  input wire [15:0] pointer_offset_1,
  input wire [15:0] gpr_pointer_offset_0,
  input wire [15:0] gpr_pointer_offset_1,
  input wire irq_out
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  property p_ofs;
    !(pointer_offset_0[0] | pointer_offset_1[0] | gpr_pointer_offset_0[0] | gpr_pointer_offset_1[0]);
  endproperty
  a_ofs: assert property (p_ofs) else $error("offset bit 0 set");
  property p_load;
    acc_load |=> accumulator == $past(acc_next_in);
  endproperty
  a_load: assert property (p_load) else $error("accumulator load lost");
  property p_bitop;
    sfr_wr && sfr_bit_op && sfr_sel == 5'h01 && !acc_load |=> $stable(accumulator[31:16]);
  endproperty
  a_bitop: assert property (p_bitop) else $error("bit write changed high word");
  property p_hi;
    coproc_store_instruction_addr == 5'h01 |=> coproc_store_instruction_rdata == $past(accumulator[31:16]);
  endproperty
  a_hi: assert property (p_hi) else $error("store high word wrong");
  property p_lo;
    coproc_store_instruction_addr == 5'h04 |=> coproc_store_instruction_rdata == $past(accumulator[15:0]);
  endproperty
  a_lo: assert property (p_lo) else $error("store low word wrong");
  property p_mas;
    coproc_store_instruction_addr == 5'h02 && (&accumulator[39:31] || ~|accumulator[39:31])
      |=> coproc_store_instruction_rdata == $past(accumulator[31:16]);
  endproperty
  a_mas: assert property (p_mas) else $error("limited word altered");
  property p_ctl;
    sfr_wr && sfr_sel == 5'h05 && sfr_byte_en[1] |=> {product_shift_mode, saturation_mode} == $past(sfr_wdata[10:9]);
  endproperty
  a_ctl: assert property (p_ctl) else $error("mode bits not written");
  property p_rep;
    repeat_load && repeat_load_count == 13'd0 ##1 repeat_step && !repeat_load |-> repeat_done;
  endproperty
  a_rep: assert property (p_rep) else $error("zero count did not end");
  property p_unmap;
    coproc_store_instruction_addr == 5'h03 |=> coproc_store_instruction_rdata == 16'h0000;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_rd;
    sfr_sel == 5'h01 |=> sfr_rdata == $past(accumulator[31:16]);
  endproperty
  a_rd: assert property (p_rd) else $error("sfr high word read wrong");
  c_irq: cover property (irq_out);
  c_done: cover property (repeat_done);
  c_load: cover property (acc_load);
endmodule // macrs_rs_monitor
bind macrs_register_set macrs_rs_monitor u_mon (.*);

// ### macrs_register_set_tb.sv
// self-checking bench of the mac register set
// assumes the host model drives the sfr and store ports
`timescale 1ns/1ps
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin errors++; $display("MISMATCH %s exp %h got %h", n, e, a); end end
module macrs_register_set_tb;
  logic ref_clk, rst_n, acc_load, flags_eval, res_carry, res_overflow, res_saturated, minmax_changed;
  logic repeat_load, repeat_step;
  logic [12:0] repeat_load_count;
  logic [39:0] acc_next_in;
  wire sfr_wr, sfr_bit_op, repeat_done, product_shift_mode, saturation_mode, irq_out;
  wire [4:0] sfr_sel, coproc_store_instruction_addr;
  wire [1:0] sfr_byte_en;
  wire [15:0] sfr_wdata, sfr_rdata, coproc_store_instruction_rdata, operand_pointer_zero, operand_pointer_one;
  wire [15:0] pointer_offset_0, pointer_offset_1, gpr_pointer_offset_0, gpr_pointer_offset_1;
  wire [39:0] accumulator;
  int errors, checks_done;
  macrs_register_set dut (.*);
  macrs_host_model h (.*);
  initial begin
    ref_clk = 0;
    forever #50 ref_clk = ~ref_clk;
  end
  task conclude;
    if (errors == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task ev(input [39:0] a, input e, input [3:0] f);
    @(posedge ref_clk) #1;
    {acc_load, flags_eval, acc_next_in} = {1'b1, e, a};
    {res_carry, res_overflow, res_saturated, minmax_changed} = f;
    @(posedge ref_clk) #1;
    {acc_load, flags_eval, res_carry, res_overflow, res_saturated, minmax_changed} = '0;
    acc_next_in = ~a;
  endtask
  task t_regs;
    logic [15:0] d;
    for (int s = 8; s < 14; s++) begin
      h.wr(s[4:0], 2'b11, 16'hffff, 1'b0);
      h.rd(s[4:0], d);
      `CHK("ptr", (s > 9) ? 16'hfffe : 16'hffff, d)
    end
    `CHK("ptr0_out", 16'hffff, operand_pointer_zero)
    `CHK("ptr1_out", 16'hffff, operand_pointer_one)
    `CHK("qx0_out", 16'hfffe, pointer_offset_0)
    `CHK("qx1_out", 16'hfffe, pointer_offset_1)
    `CHK("qr0_out", 16'hfffe, gpr_pointer_offset_0)
    `CHK("qr1_out", 16'hfffe, gpr_pointer_offset_1)
    h.wr(5'h01, 2'b11, 16'h1234, 1'b0);
    h.wr(5'h01, 2'b01, 16'hff56, 1'b0);
    h.rd(5'h01, d);
    `CHK("lane", 16'h0056, d)
    h.wr(5'h01, 2'b11, 16'hffff, 1'b1);
    h.rd(5'h01, d);
    `CHK("bitop", 16'h0056, d)
    h.wr(5'h05, 2'b11, 16'hffff, 1'b0);
    h.co(5'h05, d);
    `CHK("ctl", 16'hfe00, d)
    `CHK("modes", 2'b11, {product_shift_mode, saturation_mode})
    h.wr(5'h05, 2'b10, 16'h00ff, 1'b0);
    h.wr(5'h00, 2'b11, 16'hffff, 1'b0);
    h.rd(5'h00, d);
    `CHK("stat", 16'h3fff, d)
    h.ack;
  endtask
  task t_acc;
    logic [15:0] d;
    ev(40'h80_1234_5678, 1'b0, 4'h0);
    `CHK("acc", 40'h80_1234_5678, accumulator)
    h.rd(5'h00, d);
    `CHK("move", 16'h0080, d)
    h.co(5'h01, d);
    `CHK("hi", 16'h1234, d)
    h.co(5'h04, d);
    `CHK("lo", 16'h5678, d)
    h.co(5'h03, d);
    `CHK("unmap", 16'h0000, d)
    ev(40'h80_1234_5678, 1'b1, 4'b1100);
    h.rd(5'h00, d);
    `CHK("flags", 16'h1d80, d)
    h.co(5'h02, d);
    `CHK("limneg", 16'h8000, d)
    ev(40'h00_8000_0000, 1'b1, 4'h0);
    h.rd(5'h00, d);
    `CHK("sticky", 16'h1800, d)
    h.co(5'h02, d);
    `CHK("limpos", 16'h7fff, d)
    ev(40'h0, 1'b1, 4'b0001);
    h.rd(5'h00, d);
    `CHK("limit", 16'h2a00, d)
    h.ack;
  endtask
  task t_irq;
    logic [15:0] d;
    for (int i = 0; i < 4; i++) begin
      h.wr(5'h05, 2'b11, 16'h8000 | (16'h0800 << i), 1'b0);
      `CHK("idle", 1'b0, irq_out)
      ev((i == 2) ? 40'h01_0000_0000 : 40'h0, 1'b1, {i == 0, i == 1, i == 3, 1'b0});
      `CHK("irq", 1'b1, irq_out)
      h.rd(5'h00, d);
      `CHK("req", 16'h8000 | (16'h0400 << i) | ((i == 2) ? 16'h0001 : 16'h0200), d)
      h.wr(5'h05, 2'b11, 16'h7800, 1'b0);
      `CHK("gie", 1'b0, irq_out)
      h.wr(5'h05, 2'b11, 16'hf800 & ~(16'h0800 << i), 1'b0);
      `CHK("mask", 1'b0, irq_out)
      h.wr(5'h05, 2'b11, 16'h0000, 1'b0);
      h.ack;
      h.rd(5'h00, d);
      `CHK("clr", 16'h0000, d)
    end
  endtask
  task t_rep(input [12:0] n);
    logic [15:0] d;
    @(posedge ref_clk) #1;
    {repeat_load, repeat_load_count} = {1'b1, n};
    @(posedge ref_clk) #1;
    repeat_load = 0;
    repeat_load_count = ~n;
    h.co(5'h06, d);
    `CHK("rep", {3'b100, n}, d)
    for (int k = 0; k <= n; k++) begin
      @(posedge ref_clk) #1;
      repeat_step = 1;
      #1 `CHK("done", k == n, repeat_done)
    end
    @(posedge ref_clk) #1;
    repeat_step = 0;
    h.co(5'h06, d);
    `CHK("rep_end", 16'h0000, d)
  endtask
  initial begin
    {rst_n, acc_load, flags_eval, res_carry, res_overflow, res_saturated, minmax_changed} = '0;
    {repeat_load, repeat_step, repeat_load_count, acc_next_in} = '0;
    repeat (12) @(posedge ref_clk);
    #1 rst_n = 1;
    t_regs;
    t_acc;
    t_irq;
    t_rep(13'd0);
    t_rep(13'd2);
    conclude;
  end
  initial begin
    #2000000;
    errors++;
    conclude;
  end
endmodule // macrs_register_set_tb
